// ===== design/pin_mux_pkg.sv
// constants for the shared add-bus / line-clock pin multiplexer
package pin_mux_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] line_drive_control_ch1_addr = 16'h2f80;
  localparam logic [15:0] io_control_ch8_addr         = 16'h9f01;
  localparam logic [7:0]  line_drive_control_ch1_rst  = 8'h00;
  localparam logic [7:0]  io_control_ch8_rst          = 8'h00;
  localparam logic [7:0]  unmapped_read_value         = 8'h00;
  // ****************************************
  // field positions
  // ****************************************
  localparam int general_output_bit     = 1;
  localparam int line_clock_edge_select = 1;
  // ****************************************
  // positions in the synchroniser vector
  // ****************************************
  localparam int pin_count = 5;
  localparam int idx_ch0_pin   = 0;
  localparam int idx_ch0_clock = 1;
  localparam int idx_ch1_pin   = 2;
  localparam int idx_ch1_clock = 3;
  localparam int idx_line_data = 4;
endpackage

// ===== design/shared_add_bus_line_pin_mux.sv
// shared add-bus pins: ch0 top bit or line clock 8, ch1 low bit or gpo
//
// Summary of operation
// - channel 0 bus on: capture shared bit on add-bus clock 0 falling edge.
// - channel 0 shared pin is bit 7, the byte's top bit.
// - channel 0 bus off: the pin is the channel 8 recovered line clock.
// - line clock mode samples channel 8 data on the falling edge by default.
// - DS3/E3: clock-invert bit 1 of io control set selects rising edge.
// - STS-1 line mode always samples on the falling edge.
// - channel 1 bus on: pin is bit 0, captured on add-bus clock 1 fall.
// - channel 1 bus off: pin drives bit 1 of the line drive register.
`timescale 1ns/1ps
module shared_add_bus_line_pin_mux #(
  parameter int addr_width = 16
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // mode selection
  input  wire logic                  ch0_bus_enable,
  input  wire logic                  ch1_bus_enable,
  input  wire logic                  line_mode_sts1,
  // register port
  input  wire logic [addr_width-1:0] reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  // channel 0 shared pin and its clock
  input  wire logic                  add_bus_ch0_bit_top,
  output logic                       add_bus_ch0_bit_top_value,
  output logic                       add_bus_ch0_bit_top_oe,
  input  wire logic                  add_bus_ch0_clock,
  // channel 1 shared pin and its clock
  input  wire logic                  add_bus_ch1_bit_low,
  output logic                       general_output_ch1,
  output logic                       add_bus_ch1_bit_low_oe,
  input  wire logic                  add_bus_ch1_clock,
  // channel 8 line data
  input  wire logic                  line_data_in_ch8,
  // captured bits
  output logic                       ch0_top_bit,
  output logic                       ch0_top_strobe,
  output logic                       ch1_low_bit,
  output logic                       ch1_low_strobe,
  output logic                       line_data_ch8,
  output logic                       line_data_ch8_strobe
);
  if (addr_width < 16) begin : g_bad
    $error("addr_width must be at least 16");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [pin_mux_pkg::pin_count-1:0] sync1;
    logic [pin_mux_pkg::pin_count-1:0] sync2;
    logic [pin_mux_pkg::pin_count-1:0] prev;
    logic [7:0] line_drive_control_ch1;
    logic [7:0] io_control_ch8;
    logic [7:0] rdata;
    logic       ch0_bit;
    logic       ch0_stb;
    logic       ch1_bit;
    logic       ch1_stb;
    logic       line_bit;
    logic       line_stb;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic [pin_mux_pkg::pin_count-1:0] pins_in;
  logic [pin_mux_pkg::pin_count-1:0] rise;
  logic [pin_mux_pkg::pin_count-1:0] fall;
  logic [15:0]                       addr16;
  logic                              use_rising;

  assign pins_in = {line_data_in_ch8, add_bus_ch1_clock, add_bus_ch1_bit_low,
                    add_bus_ch0_clock, add_bus_ch0_bit_top};
  assign addr16  = reg_addr[15:0];
  // edges only from the second stage, never the first
  assign rise = state_q.sync2 & ~state_q.prev;
  assign fall = ~state_q.sync2 & state_q.prev;
  // the invert bit is ignored in STS-1 mode
  assign use_rising =
    state_q.io_control_ch8[pin_mux_pkg::line_clock_edge_select]
    & ~line_mode_sts1;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d          = state_q;
    state_d.sync1    = pins_in;
    state_d.sync2    = state_q.sync1;
    state_d.prev     = state_q.sync2;
    state_d.ch0_stb  = 1'b0;
    state_d.ch1_stb  = 1'b0;
    state_d.line_stb = 1'b0;
    if (ch0_bus_enable) begin
      if (fall[pin_mux_pkg::idx_ch0_clock]) begin
        state_d.ch0_bit = state_q.sync2[pin_mux_pkg::idx_ch0_pin];
        state_d.ch0_stb = 1'b1;
      end
    end else begin
      // pin now carries the recovered line clock
      if (use_rising ? rise[pin_mux_pkg::idx_ch0_pin]
                     : fall[pin_mux_pkg::idx_ch0_pin]) begin
        state_d.line_bit = state_q.sync2[pin_mux_pkg::idx_line_data];
        state_d.line_stb = 1'b1;
      end
    end
    if (ch1_bus_enable && fall[pin_mux_pkg::idx_ch1_clock]) begin
      state_d.ch1_bit = state_q.sync2[pin_mux_pkg::idx_ch1_pin];
      state_d.ch1_stb = 1'b1;
    end
    if (reg_wr) begin
      unique case (addr16)
        pin_mux_pkg::line_drive_control_ch1_addr:
          state_d.line_drive_control_ch1 = reg_wdata;
        pin_mux_pkg::io_control_ch8_addr:
          state_d.io_control_ch8 = reg_wdata;
        default: ;
      endcase
    end
    unique case (addr16)
      pin_mux_pkg::line_drive_control_ch1_addr:
        state_d.rdata = state_q.line_drive_control_ch1;
      pin_mux_pkg::io_control_ch8_addr:
        state_d.rdata = state_q.io_control_ch8;
      default:
        state_d.rdata = pin_mux_pkg::unmapped_read_value;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= '0;
      // synchronisers keep running through reset, so that no false edge
      // appears on release whatever the idle level of a pin
      state_q.sync1 <= state_d.sync1;
      state_q.sync2 <= state_d.sync2;
      state_q.prev  <= state_d.prev;
      state_q.line_drive_control_ch1 <=
        pin_mux_pkg::line_drive_control_ch1_rst;
      state_q.io_control_ch8         <= pin_mux_pkg::io_control_ch8_rst;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // channel 0 pin is only ever an input here; line clock is an input too
  assign add_bus_ch0_bit_top_value = 1'b0;
  assign add_bus_ch0_bit_top_oe    = 1'b0;
  assign general_output_ch1 =
    state_q.line_drive_control_ch1[pin_mux_pkg::general_output_bit];
  assign add_bus_ch1_bit_low_oe = ~ch1_bus_enable;
  assign reg_rdata            = state_q.rdata;
  assign ch0_top_bit          = state_q.ch0_bit;
  assign ch0_top_strobe       = state_q.ch0_stb;
  assign ch1_low_bit          = state_q.ch1_bit;
  assign ch1_low_strobe       = state_q.ch1_stb;
  assign line_data_ch8        = state_q.line_bit;
  assign line_data_ch8_strobe = state_q.line_stb;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_CH0_CAPTURE: assert property (
    ch0_bus_enable && fall[pin_mux_pkg::idx_ch0_clock]
    |=> ch0_top_strobe)
    else $error("channel 0 falling edge not captured");
  AST_CH0_TOP_BIT: assert property (
    ch0_bus_enable && fall[pin_mux_pkg::idx_ch0_clock]
    |=> ch0_top_bit == $past(state_q.sync2[pin_mux_pkg::idx_ch0_pin]))
    else $error("channel 0 captured bit wrong");
  AST_CH0_OFF_NO_BUS: assert property (
    !ch0_bus_enable |=> !ch0_top_strobe)
    else $error("channel 0 captured while bus disabled");
  AST_LINE_FALL: assert property (
    !ch0_bus_enable && !use_rising && fall[pin_mux_pkg::idx_ch0_pin]
    |=> line_data_ch8_strobe
        && line_data_ch8 == $past(state_q.sync2[pin_mux_pkg::idx_line_data]))
    else $error("line data not sampled on falling edge");
  AST_LINE_RISE: assert property (
    !ch0_bus_enable && !line_mode_sts1
    && state_q.io_control_ch8[pin_mux_pkg::line_clock_edge_select]
    && rise[pin_mux_pkg::idx_ch0_pin]
    |=> line_data_ch8_strobe)
    else $error("line data not sampled on rising edge");
  AST_STS1_NO_RISE: assert property (
    line_mode_sts1 && rise[pin_mux_pkg::idx_ch0_pin] |=> !line_data_ch8_strobe)
    else $error("rising edge used in STS-1 mode");
  AST_CH1_CAPTURE: assert property (
    ch1_bus_enable && fall[pin_mux_pkg::idx_ch1_clock]
    |=> ch1_low_strobe
        && ch1_low_bit == $past(state_q.sync2[pin_mux_pkg::idx_ch1_pin]))
    else $error("channel 1 falling edge not captured");
  AST_GPO_FOLLOWS: assert property (
    reg_wr && addr16 == pin_mux_pkg::line_drive_control_ch1_addr
    && !ch1_bus_enable ##1 !ch1_bus_enable
    |-> add_bus_ch1_bit_low_oe
        && general_output_ch1
           == $past(reg_wdata[pin_mux_pkg::general_output_bit]))
    else $error("general output does not follow register");
  AST_CH1_OFF_NO_BUS: assert property (
    !ch1_bus_enable |=> !ch1_low_strobe)
    else $error("channel 1 captured while bus disabled");
  AST_LINE_OFF_IN_BUS: assert property (
    ch0_bus_enable |=> !line_data_ch8_strobe)
    else $error("line data sampled while channel 0 bus enabled");
  AST_OE_OFF: assert property (
    ch1_bus_enable |-> !add_bus_ch1_bit_low_oe && !add_bus_ch0_bit_top_oe)
    else $error("shared pin driven while bus enabled");

  COV_CH0_BYTE: cover property (ch0_top_strobe);
  COV_LINE_RISE: cover property (
    use_rising && !ch0_bus_enable && rise[pin_mux_pkg::idx_ch0_pin]);
  COV_CH1_BYTE: cover property (ch1_low_strobe);
  COV_GPO_HIGH: cover property (add_bus_ch1_bit_low_oe && general_output_ch1);
  COV_STS1_FALL: cover property (
    line_mode_sts1 && line_data_ch8_strobe);
endmodule // shared_add_bus_line_pin_mux

// ===== test/add_bus_source_model.sv
// far-side model: add-bus source and line interface unit
`timescale 1ns/1ps
module add_bus_source_model (
  // shared pins, clocks and line data
  output logic p0,
  output logic k0,
  output logic p1,
  output logic k1,
  output logic ld
);
  // clocks idle high; released data shows the inverse of its last value
  initial {p0, k0, p1, k1, ld} = 5'h1f;
  task automatic bus_beat(input int ch, input logic b);
    if (ch == 0) p0 = b;
    else p1 = b;
    #80;
    if (ch == 0) k0 = 0;
    else k1 = 0;
    #80;
    {k0, k1} = 2'h3;
    #80;
    if (ch == 0) p0 = ~b;
    else p1 = ~b;
  endtask
  // different data at each clock edge tells which edge was used
  task automatic line_beat(input logic df, input logic dr);
    ld = df;
    #40 p0 = 0;
    #40 ld = dr;
    #40 p0 = 1;
    #40 ld = ~dr;
  endtask
endmodule // add_bus_source_model

// ===== test/shared_add_bus_line_pin_mux_tb_top.sv
// bench for the shared add-bus pin multiplexer
`timescale 1ns/1ps
module shared_add_bus_line_pin_mux_tb_top;
  // ****
  // stimulus, observed outputs, counters
  // ****
  logic clk = 0, srst = 1, en0 = 0, en1 = 0, sts1 = 0, wr = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, d, c0 = 0, c1 = 0, cl = 0;
  logic p0, k0, p1, k1, ld, o0, oe0, gpo, oe1, b0, s0, b1, s1, bl, sl;
  int error_cnt = 0, n_checks = 0;
  initial forever #10 clk = ~clk;
  always @(posedge clk) {c0, c1, cl} <= {c0 + s0, c1 + s1, cl + sl};
  add_bus_source_model src (.p0(p0), .k0(k0), .p1(p1), .k1(k1), .ld(ld));
  shared_add_bus_line_pin_mux dut (.clk(clk), .srst(srst),
    .ch0_bus_enable(en0), .ch1_bus_enable(en1), .line_mode_sts1(sts1),
    .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata),
    .add_bus_ch0_bit_top(p0), .add_bus_ch0_bit_top_value(o0),
    .add_bus_ch0_bit_top_oe(oe0), .add_bus_ch0_clock(k0),
    .add_bus_ch1_bit_low(p1), .general_output_ch1(gpo),
    .add_bus_ch1_bit_low_oe(oe1), .add_bus_ch1_clock(k1),
    .line_data_in_ch8(ld), .ch0_top_bit(b0), .ch0_top_strobe(s0),
    .ch1_low_bit(b1), .ch1_low_strobe(s1), .line_data_ch8(bl),
    .line_data_ch8_strobe(sl));
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic reg_wr(logic [15:0] a, logic [7:0] v);
    @(negedge clk) {addr, wdata, wr} = {a, v, 1'b1};
    @(negedge clk) wr = 0;
  endtask
  task automatic reg_rd(logic [15:0] a, output logic [7:0] v);
    @(negedge clk) addr = a;
    repeat (2) @(negedge clk);
    v = rdata;
  endtask
  task automatic t_bus(int ch);
    logic [7:0] base0, base1, basel;
    @(negedge clk) {en0, en1} = {ch == 0, ch == 1};
    {base0, base1, basel} = {c0, c1, cl};
    @(negedge clk);
    chk("oe", ch ? oe1 : oe0, 0);
    chk("oe other", ch ? oe0 : oe1, ch == 0);
    for (int i = 1; i >= 0; i--) begin
      src.bus_beat(ch, i[0]);
      repeat (4) @(negedge clk);
      chk("bit", ch ? b1 : b0, i[0]);
    end
    chk("bus strobes", ch ? c1 - base1 : c0 - base0, 2);
    chk("line strobes", cl - basel, 0);
  endtask
  task automatic t_line(logic inv, logic st, logic df, logic dr, logic e);
    logic [7:0] base0, basel;
    @(negedge clk) {en0, en1, sts1} = {2'b00, st};
    reg_wr(16'h9f01, {6'h0, inv, 1'b0});
    {base0, basel} = {c0, cl};
    src.line_beat(df, dr);
    repeat (4) @(negedge clk);
    chk("line bit", bl, e);
    chk("line strobes", cl - basel, 1);
    chk("bus strobes", c0 - base0, 0);
  endtask
  task automatic t_gpo;
    @(negedge clk) en1 = 0;
    reg_wr(16'h2f80, 8'h02);
    @(negedge clk);
    chk("gpo", {oe1, gpo}, 2'b11);
    reg_wr(16'h2f80, 8'hfd);
    @(negedge clk);
    chk("gpo", gpo, 0);
    reg_wr(16'h1234, 8'hff);
    reg_rd(16'h1234, d);
    chk("unmapped", d, 0);
    chk("gpo kept", gpo, 0);
  endtask
  // reset in mid-run brings both registers and the output back
  task automatic t_reset;
    reg_wr(16'h2f80, 8'h02);
    reg_wr(16'h9f01, 8'h02);
    @(negedge clk) srst = 1;
    repeat (3) @(negedge clk);
    srst = 0;
    chk("reset gpo", gpo, 0);
    reg_rd(16'h9f01, d);
    chk("reset io reg", d, pin_mux_pkg::io_control_ch8_rst);
    reg_rd(16'h2f80, d);
    chk("reset drive reg", d, pin_mux_pkg::line_drive_control_ch1_rst);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    srst = 0;
    reg_rd(16'h2f80, d);
    chk("drive reg", d, 0);
    chk("pin0 drive", {oe0, o0, gpo}, 0);
    t_bus(0);
    t_bus(1);
    t_line(0, 0, 1, 0, 1);
    t_line(1, 0, 0, 1, 1);
    reg_rd(16'h9f01, d);
    chk("io reg", d, 8'h02);
    t_line(1, 1, 1, 0, 1);
    t_gpo;
    t_reset;
    test_done;
  end
  // ample for the sequence above, which takes well under 20 us
  initial begin
    #200000;
    error_cnt++;
    test_done;
  end
endmodule // shared_add_bus_line_pin_mux_tb_top
